// file: gate_stage.sv
`timescale 1ns/10ps
module gate_stage (
    // Phase pins from the block
    input wire logic [three_phase_pkg::PHASE_N-1:0] phase_out,
    input wire logic [three_phase_pkg::PHASE_N-1:0] phase_oe,
    // Gate inputs as the power stage sees them
    output logic [three_phase_pkg::PHASE_N-1:0] gate_level
);
    import three_phase_pkg::*;
    // Every gate input has a pull-down, so a released pin turns its switch off.
    assign gate_level = phase_out & phase_oe;
endmodule : gate_stage

// file: pin_sync.sv
`timescale 1ns/10ps
module pin_sync (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Pin and synchronised view
    input wire logic pin_async,
    output logic level,
    output logic fall
);
    import three_phase_pkg::*;
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // Reset to the idle-high level so a reset never looks like a shutdown edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= SHUTDOWN_SYNC_RESET;
            sync_reg <= SHUTDOWN_SYNC_RESET;
            prev_reg <= SHUTDOWN_SYNC_RESET;
        end else if (ce) begin
            meta_reg <= pin_async;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign fall = prev_reg & ~sync_reg;
endmodule : pin_sync

// file: tb_three_phase_output_control.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_three_phase_output_control;
    import three_phase_pkg::*;
    logic aclk = '0, aresetn = '0, ce = '1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic carrier_underflow = '0, companion_running = '0, shutdown_input = '1, dead_time_enable, irq;
    logic [PHASE_N-1:0] phase_drive = '0, phase_out, phase_oe, pin_level;
    int err_total = 0, n_checks = 0;
    logic [67:0] exp_q[$];
    three_phase_output_control u_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .carrier_underflow, .companion_running,
        .phase_drive, .shutdown_input, .phase_out, .phase_oe, .dead_time_enable, .irq);
    gate_stage u_gate (.phase_out, .phase_oe, .gate_level(pin_level));
    initial forever #50 aclk = ~aclk;
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        int t = 0;
        bit done;
        exp_q.push_back({2'h3, 32'h0, r, 32'h0});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= '1;
        s_axi_wvalid <= '1;
        do begin
            @(posedge aclk);
            t++;
            done = s_axi_bvalid && s_axi_bready;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= '0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= '0;
            s_axi_bready <= !done && !s_axi_awvalid && !s_axi_wvalid;
        end while (!done && t < 50);
        if (!done) `CHK(done, 1'b1)
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff,
                      input logic [1:0] r = RESP_OKAY);
        int t = 0;
        bit done;
        exp_q.push_back({2'h3, m, r, e & m});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= '1;
        do begin
            @(posedge aclk);
            t++;
            done = s_axi_rvalid && s_axi_rready;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= '0;
            s_axi_rready <= !done && !s_axi_arvalid;
        end while (!done && t < 50);
        if (!done) `CHK(done, 1'b1)
    endtask : rd
    task automatic uf();
        @(posedge aclk);
        carrier_underflow <= '1;
        @(posedge aclk);
        carrier_underflow <= '0;
        cyc(3);
    endtask : uf
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    // Results are paired with the oldest note, so only one bus operation may be in flight.
    always @(posedge aclk) begin
        logic [67:0] e;
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            e = exp_q.size() ? exp_q.pop_front() : '1;
            `CHK((s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}) & e[67:34], e[33:0])
        end
    end
    initial begin
        #500000;
        `CHK(1'b0, 1'b1)
        wrap_up();
    end
    initial begin
        int n;
        logic [3:0] cnt;
        void'($urandom(47));
        cyc(8);
        aresetn <= '1;
        rd(CTRL_OFFSET, CTRL_RESET);
        rd(RELOAD_OFFSET, 32'h0);
        rd(STATUS_OFFSET, 32'h0);
        rd(MASK_OFFSET, 32'h0);
        rd(8'h20, 32'h0, 32'hffff_ffff, RESP_SLVERR);
        wr(8'h24, 32'h1, RESP_SLVERR);
        `CHK(pin_level, 6'h00)
        wr(CTRL_OFFSET, 32'h0000_000c);
        repeat (4) begin
            phase_drive <= 6'($urandom);
            cyc(2);
            `CHK(pin_level, phase_drive)
            `CHK(phase_oe, 6'h3f)
            `CHK(dead_time_enable, 1'h1)
        end
        wr(CTRL_OFFSET, 32'h0000_0004);
        cyc(1);
        `CHK(phase_oe, 6'h00)
        `CHK(pin_level, 6'h00)
        wr(MASK_OFFSET, 32'h0000_0007);
        wr(RELOAD_OFFSET, 32'h0000_0003);
        wr(CTRL_OFFSET, 32'h0000_0007);
        cnt = '0;
        repeat (3) begin
            uf();
            cnt++;
            `CHK(irq, 1'h1)
            wr(STATUS_OFFSET, 32'h0000_0001);
            `CHK(irq, 1'h0)
        end
        rd(COUNT_OFFSET, {28'h0, cnt}, 32'h0000_000f);
        wr(CTRL_OFFSET, 32'h0000_0806);
        uf();
        rd(COUNT_OFFSET, {28'h0, cnt}, 32'h0000_000f);
        companion_running <= '1;
        uf();
        cnt++;
        rd(COUNT_OFFSET, {28'h0, cnt}, 32'h0000_000f);
        ce <= '0;
        uf();
        ce <= '1;
        rd(COUNT_OFFSET, {28'h0, cnt}, 32'h0000_000f);
        wr(STATUS_OFFSET, 32'h0000_0001);
        n = 2 + $urandom % 4;
        wr(RELOAD_OFFSET, 32'(n));
        wr(CTRL_OFFSET, 32'h0000_0805);
        for (int i = 1; i <= 2 * n; i++) begin
            uf();
            `CHK(irq, logic'(i % n == n - 1))
            wr(STATUS_OFFSET, 32'h0000_0001);
        end
        wr(CTRL_OFFSET, 32'h0000_000c);
        cyc(1);
        `CHK(phase_oe, 6'h3f)
        shutdown_input <= '0;
        cyc(6);
        `CHK(phase_oe, 6'h00)
        `CHK(irq, 1'h1)
        wr(CTRL_OFFSET, 32'h0000_000c);
        rd(CTRL_OFFSET, 32'h0000_0004, 32'h0000_083f);
        shutdown_input <= '1;
        cyc(4);
        wr(STATUS_OFFSET, 32'h0000_0004);
        wr(CTRL_OFFSET, 32'h0000_000c);
        rd(CTRL_OFFSET, 32'h0000_000c, 32'h0000_083f);
        wr(CTRL_OFFSET, 32'h0000_001c);
        phase_drive <= 6'h09;
        cyc(4);
        `CHK(phase_oe, 6'h00)
        rd(CTRL_OFFSET, 32'h0000_0034, 32'h0000_083f);
        phase_drive <= 6'h01;
        wr(CTRL_OFFSET, 32'h0000_001c);
        rd(CTRL_OFFSET, 32'h0000_0034, 32'h0000_083f);
        wr(STATUS_OFFSET, 32'h0000_0002);
        wr(CTRL_OFFSET, 32'h0000_001c);
        rd(CTRL_OFFSET, 32'h0000_001c, 32'h0000_083f);
        cyc(4);
        wrap_up();
    end
endmodule : tb_three_phase_output_control

// file: thin_if.sv
`timescale 1ns/10ps
interface thin_if #(parameter int W = 4);
    logic tick;
    logic thin_on;
    logic load;
    logic [W-1:0] reload;
    logic irq;
    logic [W-1:0] uf_count;
    modport ctl (output tick, output thin_on, output load, output reload, input irq, input uf_count);
    modport cnt (input tick, input thin_on, input load, input reload, output irq, output uf_count);
endinterface : thin_if

// file: three_phase_output_control.sv
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module three_phase_output_control #(
    parameter int CNT_W = three_phase_pkg::RELOAD_W
) (
    // Clock, reset and clock enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address and data
    input wire logic [three_phase_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [three_phase_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer side, same clock domain
    input wire logic carrier_underflow,
    input wire logic companion_running,
    input wire logic [three_phase_pkg::PHASE_N-1:0] phase_drive,
    // Shutdown pin, asynchronous
    input wire logic shutdown_input,
    // Phase pins and status
    output logic [three_phase_pkg::PHASE_N-1:0] phase_out,
    output logic [three_phase_pkg::PHASE_N-1:0] phase_oe,
    output logic dead_time_enable,
    output logic irq
);
    import three_phase_pkg::*;

    // Reload and count share byte lane 0 of the bus, so the counter stops at eight bits.
    if (CNT_W < 1 || CNT_W > 8) begin : g_bad_cnt_w
        $error("CNT_W must lie between 1 and 8");
    end
    if (PHASE_N != 2 * LEG_N) begin : g_bad_legs
        $error("PHASE_N must be twice LEG_N");
    end

    // Control and data registers.
    logic irq_thin_enable_reg;
    logic start_trigger_select_reg;
    logic three_phase_func_enable_reg;
    logic phase_output_enable_reg;
    logic shoot_through_protect_enable_reg;
    logic count_mode_select_reg;
    logic [CNT_W-1:0] underflow_count_reload_reg;
    logic [STATUS_W-1:0] status_reg;
    logic [STATUS_W-1:0] mask_reg;
    logic thin_on_reg;
    logic [PHASE_N-1:0] phase_out_reg;

    // Bus state.
    logic aw_full_reg;
    logic w_full_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    logic wr_fire;
    logic [7:0] wr_offset;
    logic [7:0] rd_offset;
    logic [31:0] wr_mask;
    logic [31:0] wr_bits;
    logic wr_ctrl;
    logic wr_reload;
    logic wr_status;
    logic wr_mask_reg;
    logic wr_hit;
    logic [31:0] rd_data;
    logic rd_hit;

    logic sd_level;
    logic sd_fall;
    logic [LEG_N-1:0] leg_overlap;
    logic sim_detect;
    logic st_trip;
    logic shoot_through_flag;
    logic thin_on;
    logic tick;
    logic trigger_open;
    logic pins_on;
    logic [STATUS_W-1:0] status_event;

    thin_if #(.W(CNT_W)) thin_bus ();

    pin_sync u_sd_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .pin_async(shutdown_input),
        .level(sd_level),
        .fall(sd_fall)
    );

    underflow_thinner u_thinner (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .bus(thin_bus)
    );

    // Write channel: address and data are taken in either order, then answered together.
    // Unmapped offsets answer SLVERR and change nothing; COUNT takes writes and ignores them.
    assign s_axi_awready = ce & ~aw_full_reg & ~bvalid_reg;
    assign s_axi_wready = ce & ~w_full_reg & ~bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign wr_offset = {awaddr_reg[7:2], 2'b00};
    assign wr_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    assign wr_bits = wdata_reg & wr_mask;
    assign wr_ctrl = wr_fire & (wr_offset == CTRL_OFFSET);
    assign wr_reload = wr_fire & (wr_offset == RELOAD_OFFSET);
    assign wr_status = wr_fire & (wr_offset == STATUS_OFFSET);
    assign wr_mask_reg = wr_fire & (wr_offset == MASK_OFFSET);
    assign wr_hit = wr_ctrl | wr_reload | wr_status | wr_mask_reg | (wr_offset == COUNT_OFFSET);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            awaddr_reg <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Read channel: one read at a time, data held in a register until taken.
    // The word is sampled at the taking edge, so later register changes do not reach rdata.
    assign s_axi_arready = ce & ~rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign rd_offset = {s_axi_araddr[7:2], 2'b00};

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        case (rd_offset)
            CTRL_OFFSET: begin
                rd_data[IRQ_THIN_ENABLE_BIT] = irq_thin_enable_reg;
                rd_data[START_TRIGGER_SELECT_BIT] = start_trigger_select_reg;
                rd_data[THREE_PHASE_FUNC_ENABLE_BIT] = three_phase_func_enable_reg;
                rd_data[PHASE_OUTPUT_ENABLE_BIT] = phase_output_enable_reg;
                rd_data[SHOOT_THROUGH_PROTECT_ENABLE_BIT] = shoot_through_protect_enable_reg;
                rd_data[SHOOT_THROUGH_FLAG_BIT] = shoot_through_flag;
                rd_data[COUNT_MODE_SELECT_BIT] = count_mode_select_reg;
            end
            RELOAD_OFFSET: rd_data[CNT_W-1:0] = underflow_count_reload_reg;
            STATUS_OFFSET: rd_data[STATUS_W-1:0] = status_reg;
            MASK_OFFSET: rd_data[STATUS_W-1:0] = mask_reg;
            COUNT_OFFSET: rd_data[CNT_W-1:0] = thin_bus.uf_count;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_data;
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Plain control bits; a byte with its strobe low keeps its old value.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_thin_enable_reg <= CTRL_RESET[IRQ_THIN_ENABLE_BIT];
            start_trigger_select_reg <= CTRL_RESET[START_TRIGGER_SELECT_BIT];
            three_phase_func_enable_reg <= CTRL_RESET[THREE_PHASE_FUNC_ENABLE_BIT];
            shoot_through_protect_enable_reg <= CTRL_RESET[SHOOT_THROUGH_PROTECT_ENABLE_BIT];
            count_mode_select_reg <= CTRL_RESET[COUNT_MODE_SELECT_BIT];
        end else if (ce && wr_ctrl) begin
            if (wstrb_reg[0]) begin
                irq_thin_enable_reg <= wdata_reg[IRQ_THIN_ENABLE_BIT];
                start_trigger_select_reg <= wdata_reg[START_TRIGGER_SELECT_BIT];
                three_phase_func_enable_reg <= wdata_reg[THREE_PHASE_FUNC_ENABLE_BIT];
                shoot_through_protect_enable_reg <= wdata_reg[SHOOT_THROUGH_PROTECT_ENABLE_BIT];
            end
            if (wstrb_reg[1]) begin
                count_mode_select_reg <= wdata_reg[COUNT_MODE_SELECT_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            underflow_count_reload_reg <= CNT_W'(RELOAD_RESET);
        end else if (ce && wr_reload && wstrb_reg[0]) begin
            underflow_count_reload_reg <= wdata_reg[CNT_W-1:0]; // [RL1]
        end
    end

    // Shoot-through: a high and low switch of one leg driven together.
    // The unregistered drive is watched, so protection trips before the pins would show it.
    genvar leg;
    generate
        for (leg = 0; leg < LEG_N; leg++) begin : g_leg
            assign leg_overlap[leg] = phase_drive[leg] & phase_drive[leg + LEG_N];
        end
    endgenerate
    assign sim_detect = |leg_overlap;
    assign st_trip = shoot_through_protect_enable_reg & sim_detect; // [RL8]
    assign shoot_through_flag = status_reg[ST_SHOOT_THROUGH_BIT];

    // The output enable: every clear source beats a software set in the same cycle.
    // Set attempts are judged on the synchronised level, two edges behind the pin.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_output_enable_reg <= CTRL_RESET[PHASE_OUTPUT_ENABLE_BIT]; // [RL8]
        end else if (ce) begin
            if (sd_fall) begin
                phase_output_enable_reg <= 1'b0; // [RL9]
            end else if (st_trip) begin
                phase_output_enable_reg <= 1'b0; // [RL8]
            end else if (wr_ctrl && wstrb_reg[0]) begin
                if (!wdata_reg[PHASE_OUTPUT_ENABLE_BIT]) begin
                    phase_output_enable_reg <= 1'b0; // [RL8]
                end else if (sd_level && !(shoot_through_protect_enable_reg && shoot_through_flag)) begin
                    phase_output_enable_reg <= 1'b1; // [RL10] [RL11]
                end
            end
        end
    end

    // Underflow counting; mode 0 ignores both the thinning and the start trigger.
    assign thin_on = count_mode_select_reg & irq_thin_enable_reg; // [RL2] [RL3]
    // Mode 1 with the start trigger selected counts nothing until the companion timer runs.
    assign trigger_open = ~count_mode_select_reg | ~start_trigger_select_reg | companion_running; // [RL2] [RL3]
    assign tick = three_phase_func_enable_reg & carrier_underflow & trigger_open; // [RL6]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thin_on_reg <= 1'b0;
        end else if (ce) begin
            thin_on_reg <= thin_on;
        end
    end

    assign thin_bus.tick = tick;
    assign thin_bus.thin_on = thin_on;
    // Loading only on the rise of thinning lets a reload written mid-run wait for the next interrupt.
    assign thin_bus.load = thin_on & ~thin_on_reg; // [RL5]
    assign thin_bus.reload = underflow_count_reload_reg;

    // Sticky status; a new event wins over a write-one-to-clear in the same cycle.
    assign status_event[ST_THIN_IRQ_BIT] = thin_bus.irq;
    assign status_event[ST_SHOOT_THROUGH_BIT] = st_trip;
    assign status_event[ST_SHUTDOWN_BIT] = sd_fall;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= STATUS_RESET;
        end else if (ce) begin
            status_reg <= (status_reg & ~(wr_status ? wr_bits[STATUS_W-1:0] : '0)) | status_event;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_reg <= MASK_RESET;
        end else if (ce && wr_mask_reg && wstrb_reg[0]) begin
            mask_reg <= wdata_reg[STATUS_W-1:0];
        end
    end

    assign irq = |(status_reg & mask_reg);

    // Phase drive is registered so the pins change on clock edges only.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_out_reg <= '0;
        end else if (ce) begin
            phase_out_reg <= three_phase_func_enable_reg ? phase_drive : '0; // [RL6]
        end
    end

    assign phase_out = phase_out_reg;
    assign pins_on = phase_output_enable_reg & three_phase_func_enable_reg;
    assign phase_oe = {PHASE_N{pins_on}}; // [RL7]
    assign dead_time_enable = three_phase_func_enable_reg; // [RL6]
endmodule : three_phase_output_control

// file: three_phase_output_control_sva.sv
`timescale 1ns/10ps
module three_phase_output_control_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Phase side
    input wire logic [three_phase_pkg::PHASE_N-1:0] phase_drive,
    input wire logic shutdown_input,
    input wire logic [three_phase_pkg::PHASE_N-1:0] phase_out,
    input wire logic [three_phase_pkg::PHASE_N-1:0] phase_oe,
    input wire logic dead_time_enable,
    input wire logic irq
);
    import three_phase_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    reset_clear_a: assert property ($rose(aresetn) |-> !irq && phase_oe == '0 && !dead_time_enable)
        else $error("Outputs not cleared by reset.");
    oe_equal_a: assert property (phase_oe == '0 || phase_oe == '1)
        else $error("Phase enables differ.");
    oe_func_a: assert property (!dead_time_enable |-> phase_oe == '0)
        else $error("Phase pins driven with function off.");
    out_off_a: assert property (!dead_time_enable && !$past(dead_time_enable) |-> phase_out == '0)
        else $error("Phase outputs active with function off.");
    out_follow_a: assert property (dead_time_enable && $past(dead_time_enable) |-> phase_out == $past(phase_drive))
        else $error("Phase outputs do not follow drive.");
    shut_fall_a: assert property ($fell(shutdown_input) |-> ##[3:4] phase_oe == '0)
        else $error("Shutdown fall did not release pins.");
    shut_low_a: assert property ((!shutdown_input) [*6] |-> phase_oe == '0)
        else $error("Pins driven while shutdown low.");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped early.");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("Read data dropped early.");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("Write taken while response pending.");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read taken while data pending.");
    cover property ($fell(shutdown_input));
    cover property ($rose(irq));
    cover property ($rose(phase_oe[0]));
endmodule : three_phase_output_control_sva
bind three_phase_output_control three_phase_output_control_sva u_sva (.aclk, .aresetn, .s_axi_awready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .phase_drive, .shutdown_input,
    .phase_out, .phase_oe, .dead_time_enable, .irq);

// file: three_phase_pkg.sv
// Behaviour
// [RL1] Software writes the reload register before enabling interrupt thinning.
// [RL2] Mode 1 counts carrier underflows as thinning and start-trigger settings allow.
// [RL3] Mode 0 counts every carrier underflow, ignoring thinning and start trigger.
// [RL4] Software starts the companion timer before the first carrier underflow.
// [RL5] Thinning with value n: first interrupt after n-1 underflows, then every n.
// [RL6] Function enable activates dead-time timer, phase output control and counter.
// [RL7] Output enable low holds all six phase outputs in high impedance.
// [RL8] Output enable clears on reset, software zero, and protected shoot-through detection.
// [RL9] Output enable clears when the shutdown input falls from high to low.
// [RL10] Writes setting output enable are ignored while shutdown input is low.
// [RL11] With protection and shoot-through flag both set, output enable never becomes one.
// [RL12] Thinning count reloads from the reload register after each generated interrupt.
package three_phase_pkg;
    localparam int PHASE_N = 6;
    localparam int LEG_N = 3;
    localparam int RELOAD_W = 4;
    localparam int ADDR_W = 8;
    // Register offsets.
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] RELOAD_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] MASK_OFFSET = 8'h0c;
    localparam logic [7:0] COUNT_OFFSET = 8'h10;
    // Control field positions.
    localparam int IRQ_THIN_ENABLE_BIT = 0;
    localparam int START_TRIGGER_SELECT_BIT = 1;
    localparam int THREE_PHASE_FUNC_ENABLE_BIT = 2;
    localparam int PHASE_OUTPUT_ENABLE_BIT = 3;
    localparam int SHOOT_THROUGH_PROTECT_ENABLE_BIT = 4;
    localparam int SHOOT_THROUGH_FLAG_BIT = 5;
    localparam int COUNT_MODE_SELECT_BIT = 11;
    // Status and mask field positions.
    localparam int ST_THIN_IRQ_BIT = 0;
    localparam int ST_SHOOT_THROUGH_BIT = 1;
    localparam int ST_SHUTDOWN_BIT = 2;
    localparam int STATUS_W = 3;
    // Values after reset.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [RELOAD_W-1:0] RELOAD_RESET = 4'h0;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 3'h0;
    localparam logic [STATUS_W-1:0] MASK_RESET = 3'h0;
    localparam logic SHUTDOWN_SYNC_RESET = 1'b1;
    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : three_phase_pkg

// file: underflow_thinner.sv
`timescale 1ns/10ps
module underflow_thinner (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Counter port
    thin_if.cnt bus
);
    import three_phase_pkg::*;
    localparam int W = $bits(bus.reload);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] uf_count_reg;
    logic irq_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
            irq_reg <= 1'b0;
        end else if (ce) begin
            irq_reg <= 1'b0;
            if (bus.load) begin
                cnt_reg <= (bus.reload == '0) ? '0 : W'(bus.reload - 1'b1); // [RL5]
            end else if (bus.tick) begin
                if (!bus.thin_on) begin
                    irq_reg <= 1'b1; // [RL3]
                end else if (cnt_reg <= W'(1)) begin
                    irq_reg <= 1'b1; // [RL5]
                    cnt_reg <= bus.reload; // [RL12]
                end else begin
                    cnt_reg <= W'(cnt_reg - 1'b1); // [RL2]
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            uf_count_reg <= '0;
        end else if (ce && bus.tick) begin
            uf_count_reg <= W'(uf_count_reg + 1'b1); // [RL2] [RL3]
        end
    end

    assign bus.irq = irq_reg;
    assign bus.uf_count = uf_count_reg;
endmodule : underflow_thinner
